// ==== core/pit_unit.sv ====
/*
 * pit_unit: priority compare and hard and soft trap generation.
 * Assumes the core drives instruction boundaries, acks and register writes
 * synchronously on clock_in; async hard trap events arrive through synchronisers.
 */
// Operation
// - sixteen levels; a source fires only when strictly above current cpu level.
// - user sources take levels zero to seven; traps use eight to fifteen.
// - cpu level is user level bits plus the trap in progress bit.
// - user level writable; writing it blocks sources at or below it.
// - trap in progress set by traps; software clears it, writes of one ignored.
// - user level read only while nesting is disabled.
// - source priority is low three bits of a nibble; top bit reads zero.
// - equal user priority resolved by lowest vector number.
// - running exception preempted only by strictly higher priority; here a trap only sets the trap bit, so lower or equal traps can preempt.
// - four traps with fixed levels, oscillator highest, arithmetic lowest.
// - trapping instruction finishes before trap exception processing.
// - soft traps take two cycles to be sampled and acknowledged.
// - stack pointer resets to 0x0800; lower address raises stack error.
// - stack limit checking off until first word write to limit register.
// - stack addresses above limit or wrapping past 0xFFFF raise stack error.
// - stack error flag set on stack trap; software clears it.
// - arithmetic trap on overflows, divide by zero, oversized accumulator shift.
// - overflow traps individually enabled by control bits ten, nine, eight; here no enables, every overflow traps.
// - overflow is carry out of 31 or 39, suppressed by saturation.
// - divide by zero has no enable, checked on first repeat iteration.
// - oversized shift traps always and its result is not written.
// - arithmetic flag set, not clearable while causes remain; overflow bits hw cleared.
// - request pending when flag set, fires only if enabled; sampled every cycle.
// - hard traps at 13 to 15, address error 13, oscillator failure 14.
`timescale 1ns/1ps
`default_nettype none
module pit_unit
    import pit_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [N-1:0] request_flag_regs_in,
    input wire logic [N-1:0] request_enable_regs_in,
    input wire logic [N*NIB_W-1:0] source_priority_regs_in,
    input wire logic upl_write_in,
    input wire logic [UPL_W-1:0] upl_wdata_in,
    input wire logic nesting_disable_in,
    input wire logic tip_clear_in,
    input wire logic tip_wdata_in,
    input wire logic instr_done_in,
    input wire logic ack_in,
    input wire logic exc_return_in,
    input wire logic osc_fail_async_in,
    input wire logic addr_error_in,
    input wire logic stack_limit_reg_word_write_in,
    input wire logic [15:0] stack_limit_reg_wdata_in,
    input wire logic sp_write_in,
    input wire logic [15:0] sp_wdata_in,
    input wire pit_stack_ea_t stack_ea_in,
    input wire pit_math_t math_in,
    input wire logic stack_error_flag_clear_in,
    input wire logic arithmetic_error_flag_clear_in,
    output pit_req_t request_out,
    output logic [UPL_W-1:0] user_priority_level_out,
    output logic trap_in_progress_bit_out,
    output logic [N*NIB_W-1:0] source_priority_rd_out,
    output logic [15:0] stack_pointer_out,
    output logic stack_error_flag_out,
    output logic arithmetic_error_flag_out,
    output logic acc_a_overflow_status_out,
    output logic acc_b_overflow_status_out,
    output logic shift_write_inhibit_out
);
    logic [UPL_W-1:0] upl;
    logic tip;
    logic [15:0] sp;
    logic [15:0] stack_limit_reg;
    logic stack_limit_reg_armed;
    logic stk_flag;
    logic math_flag;
    logic ova;
    logic ovb;
    logic osc_s1;
    logic osc_s2;
    logic [1:0] stk_pipe;
    logic [1:0] math_pipe;
    logic hard_pend_osc;
    logic hard_pend_addr;
    logic soft_pend_stk;
    logic soft_pend_math;
    pit_req_t req;
    logic [N*NIB_W-1:0] prio_rd;
    logic shift_inh;
    logic addr_seen;
    logic [N*NIB_W-1:0] next_prio_rd;

    // every check below runs on the instruction clock and sleeps through reset
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    // cpu level: trap bit forms the top bit, so any trap blocks all user sources
    wire [LVL_W-1:0] cpu_level = {tip, upl};

    // overflow detection, saturation suppresses
    wire ova_evt = math_in.acc_a_carry31 & ~math_in.sat31_a;
    wire ovb_evt = math_in.acc_b_carry31 & ~math_in.sat31_b;
    wire cov_evt = (math_in.acc_a_carry39 & ~(math_in.sat31_a | math_in.sat39_a))
                 | (math_in.acc_b_carry39 & ~(math_in.sat31_b | math_in.sat39_b));
    wire div_evt = math_in.div_first_iter & math_in.div_by_zero;
    wire signed [5:0] sft_lim = 6'(SFT_MAX);
    wire sft_evt = math_in.shift_valid &
        ((math_in.shift_amount > sft_lim) | (math_in.shift_amount < -sft_lim));
    wire math_evt = (ova_evt & 1'b1) | (ovb_evt & 1'b1) | cov_evt | div_evt | sft_evt;

    // no trap enables among the arithmetic control inputs; accumulator overflow traps ungated
    wire math_trap = math_evt & (div_evt | sft_evt | ova_evt | ovb_evt | cov_evt);
    // causes still standing stop software from clearing the arithmetic flag
    wire math_cause = ova | ovb | math_evt;

    // stack checks on pointer-relative effective addresses
    wire stk_low = stack_ea_in.valid & (stack_ea_in.ea < SP_RESET);
    wire stk_high = stack_ea_in.valid & stack_limit_reg_armed & (stack_ea_in.ea > stack_limit_reg);
    wire stk_wrap = stack_ea_in.valid & stack_ea_in.wrapped;
    wire stk_evt = stk_low | stk_high | stk_wrap;

    // trap levels above the cpu level, highest first
    wire osc_go = hard_pend_osc & (LVL_OSC > cpu_level);
    wire addr_go = hard_pend_addr & (LVL_ADDR > cpu_level);
    wire stk_go = soft_pend_stk & (LVL_STK > cpu_level);
    wire math_go = soft_pend_math & (LVL_MATH > cpu_level);

    // user arbitration: level first, lowest vector wins ties
    logic [UPL_W-1:0] best_lvl;
    logic [VEC_W-1:0] best_idx;
    logic best_hit;
    always_comb begin
        best_lvl = '0;
        best_idx = '0;
        best_hit = 1'b0;
        for (int i = 0; i < N; i++) begin
            // strict greater keeps the lowest index on a tie
            if (request_flag_regs_in[i] & request_enable_regs_in[i] &
                (source_priority_regs_in[i*NIB_W +: UPL_W] > best_lvl)) begin
                best_lvl = source_priority_regs_in[i*NIB_W +: UPL_W];
                best_idx = VEC_W'(i);
                best_hit = 1'b1;
            end
        end
    end
    // level zero can never exceed cpu level, so it is disabled implicitly
    wire user_go = best_hit & ({1'b0, best_lvl} > cpu_level);

    // final selection presented to the core
    pit_req_t next_req;
    always_comb begin
        next_req = '0;
        if (osc_go) begin
            next_req = '{1'b1, VEC_OSC, LVL_OSC};
        end else if (addr_go) begin
            next_req = '{1'b1, VEC_ADDR, LVL_ADDR};
        end else if (stk_go) begin
            next_req = '{1'b1, VEC_STK, LVL_STK};
        end else if (math_go) begin
            next_req = '{1'b1, VEC_MATH, LVL_MATH};
        end else if (user_go) begin
            next_req = '{1'b1, VEC_USER0 + best_idx, {1'b0, best_lvl}};
        end
    end

    // priority readback with the unused top bit of each nibble forced to zero
    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_prio_rd[i*NIB_W +: NIB_W] = {1'b0, source_priority_regs_in[i*NIB_W +: UPL_W]};
        end
    end

    // async oscillator fail through two flops
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
        end else begin
            osc_s1 <= osc_fail_async_in;
            osc_s2 <= osc_s1;
        end
    end

    // an address error pulse between boundaries is held here, otherwise it
    // would be lost while the core is still finishing the faulting instruction
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_seen <= 1'b0;
        end else begin
            addr_seen <= (addr_seen | addr_error_in) & ~instr_done_in;
        end
    end

    // hard traps wait for the instruction boundary before being offered
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hard_pend_osc <= 1'b0;
            hard_pend_addr <= 1'b0;
        end else begin
            hard_pend_osc <= (hard_pend_osc & ~(ack_in & request_out.vector == VEC_OSC))
                           | (osc_s2 & instr_done_in);
            hard_pend_addr <= (hard_pend_addr & ~(ack_in & request_out.vector == VEC_ADDR))
                            | ((addr_error_in | addr_seen) & instr_done_in);
        end
    end

    // soft traps walk a two-stage sampling pipe, instructions continue meanwhile
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stk_pipe <= '0;
            math_pipe <= '0;
            soft_pend_stk <= 1'b0;
            soft_pend_math <= 1'b0;
        end else begin
            stk_pipe <= {stk_pipe[0], stk_evt};
            math_pipe <= {math_pipe[0], math_trap};
            soft_pend_stk <= (soft_pend_stk & ~(ack_in & request_out.vector == VEC_STK)) | stk_pipe[1];
            soft_pend_math <= (soft_pend_math & ~(ack_in & request_out.vector == VEC_MATH)) | math_pipe[1];
        end
    end

    // cpu level: ack raises it, return restores it through software writes
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            upl <= '0;
            tip <= 1'b0;
        end else begin
            if (ack_in & request_out.valid & request_out.level[UPL_W]) begin
                tip <= 1'b1;
            end else if (tip_clear_in & ~tip_wdata_in) begin
                tip <= 1'b0;
            end
            if (ack_in & request_out.valid & ~request_out.level[UPL_W]) begin
                upl <= request_out.level[UPL_W-1:0];
            end else if (upl_write_in & ~nesting_disable_in) begin
                upl <= upl_wdata_in;
            end
        end
    end

    // stack pointer and limit; limit contents left unset, only the arm bit resets
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sp <= SP_RESET;
            stack_limit_reg_armed <= 1'b0;
        end else begin
            if (sp_write_in) begin
                sp <= sp_wdata_in;
            end
            if (stack_limit_reg_word_write_in) begin
                stack_limit_reg_armed <= 1'b1;
            end
        end
    end
    always_ff @(posedge clock_in) begin
        if (stack_limit_reg_word_write_in) begin
            stack_limit_reg <= stack_limit_reg_wdata_in;
        end
    end

    // sticky flags: set wins over clear; arithmetic clear refused while causes stand
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stk_flag <= 1'b0;
            math_flag <= 1'b0;
            ova <= 1'b0;
            ovb <= 1'b0;
            shift_inh <= 1'b0;
        end else begin
            stk_flag <= stk_evt | (stk_flag & ~stack_error_flag_clear_in);
            math_flag <= math_trap | (math_flag & ~(arithmetic_error_flag_clear_in & ~math_cause));
            ova <= ova_evt | (ova & ~math_in.op_on_acc_a);
            ovb <= ovb_evt | (ovb & ~math_in.op_on_acc_b);
            shift_inh <= sft_evt;
        end
    end

    // registered outputs
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req <= '0;
            prio_rd <= '0;
        end else begin
            req <= next_req;
            prio_rd <= next_prio_rd;
        end
    end
    assign request_out = req;
    assign user_priority_level_out = upl;
    assign trap_in_progress_bit_out = tip;
    assign source_priority_rd_out = prio_rd;
    assign stack_pointer_out = sp;
    assign stack_error_flag_out = stk_flag;
    assign arithmetic_error_flag_out = math_flag;
    assign acc_a_overflow_status_out = ova;
    assign acc_b_overflow_status_out = ovb;
    assign shift_write_inhibit_out = shift_inh;

    // checks on the cpu level, the request presented to the core, soft trap delay, trap flags and shift inhibit
    trap_blocks_user_a: assert property (tip |=> !(req.valid && !req.level[UPL_W]))
        else $error("user request while trap");
    strict_level_a: assert property (next_req.valid |-> next_req.level > cpu_level)
        else $error("level not above cpu");
    upl_locked_a: assert property (nesting_disable_in && upl_write_in && !ack_in |=> $stable(upl))
        else $error("upl written");
    tip_set_ignored_a: assert property (!tip && tip_clear_in && tip_wdata_in && !ack_in |=> !tip)
        else $error("tip set by sw");
    soft_delay_a: assert property (stk_evt |-> ##3 soft_pend_stk)
        else $error("stack trap not pending");
    stack_flag_a: assert property (stk_evt |=> stk_flag)
        else $error("stack flag missing");
    math_hold_a: assert property (math_flag && math_cause |=> math_flag)
        else $error("math flag cleared early");
    osc_first_a: assert property (osc_go |=> req.vector == VEC_OSC)
        else $error("osc not first");
    shift_inh_a: assert property (sft_evt |=> shift_inh && math_flag)
        else $error("shift not inhibited");
    // stack, arithmetic, instruction boundary, user level load and idle request checks
    limit_off_a: assert property (!stack_limit_reg_armed && !stk_low && !stk_wrap |=> !stk_pipe[0])
        else $error("limit check before arming");
    stack_high_a: assert property (stk_high |=> stk_pipe[0] && stk_flag)
        else $error("stack above limit missed");
    div_trap_a: assert property (div_evt |=> math_pipe[0] && math_flag)
        else $error("divide trap missed");
    sat_block_a: assert property (math_in.sat31_a && !ova |=> !ova)
        else $error("overflow under saturation");
    hard_wait_a: assert property (!hard_pend_addr && !instr_done_in |=> !hard_pend_addr)
        else $error("address trap before boundary");
    upl_load_a: assert property (ack_in && req.valid && !req.level[UPL_W] |=> {1'b0, upl} == $past(req.level))
        else $error("user level not loaded");
    idle_quiet_a: assert property (!(|(request_flag_regs_in & request_enable_regs_in))
        && !hard_pend_osc && !hard_pend_addr && !soft_pend_stk && !soft_pend_math |=> !req.valid)
        else $error("request with nothing pending");
    cov_user_c: cover property (user_go ##1 ack_in);
    cov_stk_c: cover property (stk_evt ##3 stk_go);
    cov_osc_c: cover property (osc_go && user_go);
    cov_math_c: cover property (math_go ##1 ack_in);
    cov_tip_c: cover property (tip && tip_clear_in && !tip_wdata_in);
endmodule : pit_unit
`default_nettype wire

// ==== core/pit_pkg.sv ====
/*
 * pit_pkg: constants and carrier types for the priority interrupt and trap unit.
 * Assumes a single instruction clock domain; all users import pit_pkg::*.
 */
package pit_pkg;
    localparam int NUM_SRC = 8;
    localparam int VEC_W = 6;
    localparam int LVL_W = 4;
    localparam int UPL_W = 3;
    localparam int NIB_W = 4;
    // status register and control register bit positions
    localparam int SR_UPL_LO = 5;
    localparam int SR_OVA_BIT = 15;
    localparam int SR_OVB_BIT = 14;
    localparam int CC_TIP_BIT = 3;
    localparam int IC1_STACK_ERROR_FLAG_BIT = 2;
    localparam int IC1_ARITHMETIC_ERROR_FLAG_BIT = 4;
    localparam int IC1_OVA_TE_BIT = 10;
    localparam int IC1_OVB_TE_BIT = 9;
    localparam int IC1_COV_TE_BIT = 8;
    // fixed trap levels and vectors
    localparam logic [3:0] LVL_OSC = 4'hE;
    localparam logic [3:0] LVL_ADDR = 4'hD;
    localparam logic [3:0] LVL_STK = 4'hC;
    localparam logic [3:0] LVL_MATH = 4'hB;
    localparam logic [5:0] VEC_OSC = 6'h01;
    localparam logic [5:0] VEC_ADDR = 6'h02;
    localparam logic [5:0] VEC_STK = 6'h03;
    localparam logic [5:0] VEC_MATH = 6'h04;
    localparam logic [5:0] VEC_USER0 = 6'h08;
    localparam logic [2:0] UPL_ALL = 3'h7;
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam logic [15:0] DATA_END = 16'hFFFF;
    localparam int SOFT_ACK_CYCLES = 2;
    localparam int SFT_MAX = 16;

    // arithmetic event from the datapath
    typedef struct packed {
        logic acc_a_carry31;
        logic acc_b_carry31;
        logic acc_a_carry39;
        logic acc_b_carry39;
        logic sat31_a;
        logic sat31_b;
        logic sat39_a;
        logic sat39_b;
        logic div_first_iter;
        logic div_by_zero;
        logic shift_valid;
        logic signed [5:0] shift_amount;
        logic op_on_acc_a;
        logic op_on_acc_b;
    } pit_math_t;

    // stack pointer effective address check request
    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic wrapped;
    } pit_stack_ea_t;

    // request presented to the core
    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vector;
        logic [LVL_W-1:0] level;
    } pit_req_t;
endpackage : pit_pkg

// ==== tb/pit_core_model.sv ====
/*
 * pit_core_model: behavioural processor core facing pit_unit.
 * Assumes one clock domain; the bench enables acks and sets their delay.
 */
`timescale 1ns/1ps
`default_nettype none
module pit_core_model
    import pit_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire pit_req_t request_in,
    input wire logic ack_enable_in,
    input wire logic [3:0] ack_delay_in,
    output logic instr_done_out,
    output logic ack_out
);
    logic [3:0] wait_count;
    logic [1:0] holdoff;
    // an instruction ends every other cycle; ack answers only a request seen valid,
    // and a holdoff keeps it from acking a request that has not yet dropped
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            instr_done_out <= 1'b0;
            ack_out <= 1'b0;
            wait_count <= 4'h0;
            holdoff <= 2'h0;
        end else begin
            instr_done_out <= ~instr_done_out;
            ack_out <= 1'b0;
            if (ack_out) begin
                holdoff <= 2'h3;
            end else if (holdoff != 2'h0) begin
                holdoff <= holdoff - 2'h1;
            end else if (ack_enable_in && request_in.valid) begin
                ack_out <= (wait_count == ack_delay_in);
                wait_count <= (wait_count == ack_delay_in) ? 4'h0 : wait_count + 4'h1;
            end else begin
                wait_count <= 4'h0;
            end
        end
    end
endmodule : pit_core_model
`default_nettype wire

// ==== tb/pit_unit_bench.sv ====
/*
 * pit_unit_bench: table-driven arbitration cases, then trap and register cases.
 * Assumes pit_pkg, pit_unit and pit_core_model; clock 100 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pit_unit_bench
    import pit_pkg::*;
;
    typedef struct packed {logic [7:0] flg; logic [7:0] en; logic [31:0] pri; logic [2:0] upl; pit_req_t exp;} pit_row_t;
    localparam logic [5:0] MATH_EXP = 6'b010011;
    logic clock_in, reset_n_in, upl_write_in, nesting_disable_in, tip_clear_in, tip_wdata_in, ack_in, instr_done_in;
    logic osc_fail_async_in, addr_error_in, stack_limit_reg_word_write_in, stack_error_flag_clear_in, arithmetic_error_flag_clear_in, ack_en;
    logic tip, stack_error_flag, arithmetic_error_flag, ova, ovb, inhibit;
    logic [7:0] flags, enables;
    logic [31:0] prio, prio_rd;
    logic [2:0] upl_wdata, upl;
    logic [15:0] stack_limit_reg_wdata, sp;
    logic [3:0] ack_delay;
    pit_stack_ea_t stack_ea;
    pit_math_t math;
    pit_req_t request;
    int bad_count = 0;
    int samples_checked = 0;
    // flags, enables, nibbles, user level, expected request
    pit_row_t rows[9] = '{
        '{8'h01, 8'h01, 32'h0000000B, 3'h0, {1'b1, 6'h08, 4'h3}}, '{8'h01, 8'h01, 32'h0, 3'h0, 11'h0},
        '{8'h03, 8'h03, 32'h00000033, 3'h0, {1'b1, 6'h08, 4'h3}}, '{8'h03, 8'h03, 32'h52, 3'h0, {1'b1, 6'h09, 4'h5}},
        '{8'h03, 8'h03, 32'h00000052, 3'h5, 11'h0}, '{8'h03, 8'h03, 32'h52, 3'h4, {1'b1, 6'h09, 4'h5}},
        '{8'h03, 8'h01, 32'h00000052, 3'h0, {1'b1, 6'h08, 4'h2}}, '{8'h80, 8'h80, 32'h70000000, 3'h7, 11'h0},
        '{8'h80, 8'h80, 32'h70000000, 3'h6, {1'b1, 6'h0F, 4'h7}}};

    pit_unit i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .request_flag_regs_in(flags),
        .request_enable_regs_in(enables), .source_priority_regs_in(prio), .upl_write_in(upl_write_in),
        .upl_wdata_in(upl_wdata), .nesting_disable_in(nesting_disable_in), .tip_clear_in(tip_clear_in),
        .tip_wdata_in(tip_wdata_in), .instr_done_in(instr_done_in), .ack_in(ack_in), .exc_return_in(1'b0),
        .osc_fail_async_in(osc_fail_async_in), .addr_error_in(addr_error_in),
        .stack_limit_reg_word_write_in(stack_limit_reg_word_write_in), .stack_limit_reg_wdata_in(stack_limit_reg_wdata), .sp_write_in(1'b0),
        .sp_wdata_in(16'h0000), .stack_ea_in(stack_ea), .math_in(math), .stack_error_flag_clear_in(stack_error_flag_clear_in),
        .arithmetic_error_flag_clear_in(arithmetic_error_flag_clear_in), .request_out(request), .user_priority_level_out(upl),
        .trap_in_progress_bit_out(tip), .source_priority_rd_out(prio_rd), .stack_pointer_out(sp),
        .stack_error_flag_out(stack_error_flag), .arithmetic_error_flag_out(arithmetic_error_flag), .acc_a_overflow_status_out(ova),
        .acc_b_overflow_status_out(ovb), .shift_write_inhibit_out(inhibit));
    pit_core_model i_core (.clock_in(clock_in), .reset_n_in(reset_n_in), .request_in(request),
        .ack_enable_in(ack_en), .ack_delay_in(ack_delay), .instr_done_out(instr_done_in), .ack_out(ack_in));

    // 100 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic set_upl(input logic [2:0] v);
        @(posedge clock_in);
        upl_write_in <= 1'b1;
        upl_wdata <= v;
        @(posedge clock_in);
        upl_write_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
    endtask : set_upl

    task automatic tip_write(input logic v);
        @(posedge clock_in);
        tip_clear_in <= 1'b1;
        tip_wdata_in <= v;
        @(posedge clock_in);
        tip_clear_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
    endtask : tip_write

    // core takes whatever trap is pending, then software drops the trap bit
    task automatic take_ack();
        @(posedge clock_in);
        ack_en <= 1'b1;
        repeat (4) @(posedge clock_in);
        ack_en <= 1'b0;
        tip_write(1'b0);
    endtask : take_ack

    // bounded wait for a given vector, then compare the whole request
    task automatic wait_req(input logic [5:0] v, input logic [3:0] l);
        for (int i = 0; i < 12 && (request.valid !== 1'b1 || request.vector !== v); i++) @(posedge clock_in);
        #1;
        `CHK(request, {1'b1, v, l})
    endtask : wait_req

    task automatic stk(input logic [15:0] ea, input logic wrap, input logic exp);
        @(posedge clock_in);
        stack_ea <= {1'b1, ea, wrap};
        @(posedge clock_in);
        stack_ea <= '0;
        repeat (5) @(posedge clock_in);
        #1;
        `CHK(stack_error_flag, exp)
        if (exp) `CHK(request, {1'b1, VEC_STK, LVL_STK})
        take_ack();
        `CHK(request.valid, 1'b0)
        @(posedge clock_in);
        stack_error_flag_clear_in <= 1'b1;
        @(posedge clock_in);
        stack_error_flag_clear_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        `CHK(stack_error_flag, 1'b0)
    endtask : stk

    task automatic clr_math();
        @(posedge clock_in);
        arithmetic_error_flag_clear_in <= 1'b1;
        @(posedge clock_in);
        arithmetic_error_flag_clear_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask : clr_math

    // one datapath event; a clear is refused while the overflow status stands
    task automatic mth(input int k, input logic exp);
        pit_math_t m;
        m = '0;
        case (k)
            0: begin m.div_first_iter = 1'b1; m.div_by_zero = 1'b1; end
            1: m.acc_a_carry31 = 1'b1;
            2: begin m.acc_a_carry31 = 1'b1; m.sat31_a = 1'b1; end
            3: begin m.acc_b_carry39 = 1'b1; m.sat39_b = 1'b1; end
            4: begin m.shift_valid = 1'b1; m.shift_amount = 6'sd17; end
            default: begin m.shift_valid = 1'b1; m.shift_amount = -6'sd16; end
        endcase
        @(posedge clock_in);
        math <= m;
        @(posedge clock_in);
        math <= '0;
        #1;
        `CHK(inhibit, 1'(k == 4))
        repeat (4) @(posedge clock_in);
        #1;
        `CHK(arithmetic_error_flag, exp)
        `CHK(ova, 1'(k == 1))
        if (exp) `CHK(request, {1'b1, VEC_MATH, LVL_MATH})
        clr_math();
        `CHK(arithmetic_error_flag, 1'(k == 1))
        @(posedge clock_in);
        math.op_on_acc_a <= 1'b1;
        @(posedge clock_in);
        math <= '0;
        clr_math();
        `CHK({arithmetic_error_flag, ova}, 2'b00)
    endtask : mth

    initial begin
        {reset_n_in, upl_write_in, nesting_disable_in, tip_clear_in, tip_wdata_in, ack_en} = '0;
        {osc_fail_async_in, addr_error_in, stack_limit_reg_word_write_in, stack_error_flag_clear_in, arithmetic_error_flag_clear_in} = '0;
        {flags, enables, prio, upl_wdata, stack_limit_reg_wdata, stack_ea, math} = '0;
        ack_delay = 4'h0;
        repeat (20) @(posedge clock_in);
        #1;
        `CHK({request.valid, upl, tip, stack_error_flag, arithmetic_error_flag}, 7'h00)
        `CHK(sp, SP_RESET)
        @(posedge clock_in);
        reset_n_in <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clock_in);
            flags <= rows[i].flg;
            enables <= rows[i].en;
            prio <= rows[i].pri;
            set_upl(rows[i].upl);
            `CHK(upl, rows[i].upl)
            `CHK(prio_rd, rows[i].pri & 32'h77777777)
            if (rows[i].exp.valid) `CHK(request, rows[i].exp)
            else `CHK(request.valid, 1'b0)
        end
        @(posedge clock_in);
        nesting_disable_in <= 1'b1;
        set_upl(3'h3);
        `CHK(upl, 3'h6)
        @(posedge clock_in);
        nesting_disable_in <= 1'b0;
        flags <= 8'h02;
        enables <= 8'h02;
        prio <= 32'h50;
        set_upl(3'h0);
        // core accepts the level 5 source, then a lower vector at level 5 must wait
        @(posedge clock_in);
        ack_en <= 1'b1;
        for (int i = 0; i < 20 && upl !== 3'h5; i++) @(posedge clock_in);
        ack_en <= 1'b0;
        #1;
        `CHK(upl, 3'h5)
        @(posedge clock_in);
        flags <= 8'h03;
        enables <= 8'h03;
        prio <= 32'h55;
        repeat (3) @(posedge clock_in);
        #1;
        `CHK(request.valid, 1'b0)
        @(posedge clock_in);
        flags <= 8'h07;
        enables <= 8'h07;
        prio <= 32'h655;
        wait_req(6'h0A, 4'h6);
        @(posedge clock_in);
        flags <= 8'h00;
        set_upl(3'h0);
        stk(16'h0400, 1'b0, 1'b1);
        stk(16'hF000, 1'b0, 1'b0);
        @(posedge clock_in);
        stack_limit_reg_word_write_in <= 1'b1;
        stack_limit_reg_wdata <= 16'h0900;
        @(posedge clock_in);
        stack_limit_reg_word_write_in <= 1'b0;
        stk(16'h0A00, 1'b0, 1'b1);
        stk(16'h0900, 1'b0, 1'b0);
        stk(16'h0850, 1'b1, 1'b1);
        for (int k = 0; k < 6; k++) mth(k, MATH_EXP[k]);
        // a slow core acks the arithmetic trap; the trap bit can then only be cleared
        @(posedge clock_in);
        math.div_first_iter <= 1'b1;
        math.div_by_zero <= 1'b1;
        ack_en <= 1'b1;
        ack_delay <= 4'h3;
        @(posedge clock_in);
        math <= '0;
        for (int i = 0; i < 20 && tip !== 1'b1; i++) @(posedge clock_in);
        ack_en <= 1'b0;
        #1;
        `CHK(tip, 1'b1)
        clr_math();
        tip_write(1'b0);
        `CHK(tip, 1'b0)
        tip_write(1'b1);
        `CHK(tip, 1'b0)
        @(posedge clock_in);
        flags <= 8'h80;
        enables <= 8'h80;
        prio <= 32'h70000000;
        addr_error_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        addr_error_in <= 1'b0;
        wait_req(VEC_ADDR, LVL_ADDR);
        @(posedge clock_in);
        osc_fail_async_in <= 1'b1;
        wait_req(VEC_OSC, LVL_OSC);
        final_report();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        #50us;
        bad_count++;
        final_report();
    end
endmodule : pit_unit_bench
`default_nettype wire
